// file: verilog/vspl_defs.vh
`ifndef VSPL_DEFS_VH
`define VSPL_DEFS_VH

// register byte addresses
`define VSPL_A_CTRL 8'h00
`define VSPL_A_USET 8'h04
`define VSPL_A_ULH 8'h08
`define VSPL_A_ULL 8'h0c
`define VSPL_A_VLO 8'h10
`define VSPL_A_VHI 8'h14
`define VSPL_A_ILO 8'h18
`define VSPL_A_IHI 8'h1c
`define VSPL_A_LOCATION_DWELL_TIME 8'h20
`define VSPL_A_LOCSEL 8'h24
`define VSPL_A_DEFAULT_DWELL_TIME 8'h28
`define VSPL_A_WAIT 8'h2c
`define VSPL_A_CRB 8'h30
`define VSPL_A_ERC 8'h34
`define VSPL_A_UMAX 8'h38
`define VSPL_A_UMIN 8'h3c
`define VSPL_A_IMAX 8'h40
`define VSPL_A_IMIN 8'h44
`define VSPL_A_UOUT 8'h48
`define VSPL_A_XRST 8'h4c

// control register fields
`define VSPL_CTRL_EXTREME_VALUE_TRACKING 0
`define VSPL_CTRL_SIG_LSB 2

// event register bits
`define VSPL_EV_VBAND 0
`define VSPL_EV_IBAND 1
`define VSPL_EV_LIMIT 2
`define VSPL_EV_CMD 3

// value scale: 100 uV / 100 uA per lsb, 20 bits
`define VSPL_UNOM 20'h927c0
`define VSPL_INOM 20'h186a0
`define VSPL_RES 21'h00000a
`define VSPL_RES_HALF 21'h000005

// reset values
`define VSPL_RST_ZERO 20'h00000
`define VSPL_RST_LOCATION_DWELL_TIME 16'h0000
`define VSPL_RST_DEFAULT_DWELL_TIME 16'h0001
`define VSPL_DWELL_MAX 16'hffff

// data string codes for out of range measurements
`define VSPL_OVR_CODE 32'h000f423f
`define VSPL_UND_CODE 32'hfff0bdc1

// timing: core clock cycles per millisecond at 100 MHz
`define VSPL_MS_CYC 17'h186a0

`define VSPL_RESP_OKAY 2'b00
`define VSPL_RESP_SLVERR 2'b10

`endif

// file: verilog/vspl_ms_timer.v
`timescale 1ns/1ns
`include "vspl_defs.vh"

module vspl_ms_timer #(
    parameter [16:0] MS_CYC = `VSPL_MS_CYC
) (
    input wire core_clk,
    input wire rst_n,
    input wire start,
    input wire [15:0] loadMs,
    output reg busy_r,
    output reg done_r
);

reg [16:0] cycCnt_r;
reg [15:0] msCnt_r;

always @(posedge core_clk) begin
    if (!rst_n) begin
        busy_r <= 1'b0;
        done_r <= 1'b0;
        cycCnt_r <= 17'h00000;
        msCnt_r <= 16'h0000;
    end else begin
        done_r <= 1'b0;
        if (start && loadMs != 16'h0000) begin
            busy_r <= 1'b1;
            cycCnt_r <= MS_CYC - 17'h00001;
            msCnt_r <= loadMs;
        end else if (busy_r) begin
            if (cycCnt_r != 17'h00000) begin
                cycCnt_r <= cycCnt_r - 17'h00001;
            end else if (msCnt_r == 16'h0001) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
                msCnt_r <= 16'h0000;
            end else begin
                msCnt_r <= msCnt_r - 16'h0001;
                cycCnt_r <= MS_CYC - 17'h00001;
            end
        end
    end
end

endmodule // vspl_ms_timer

// file: verilog/vspl_cmd_core.v
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "vspl_defs.vh"

// Function
// - per-location dwell 0..65535 ms, reset zero
// - zero location dwell uses default dwell
// - four band references, ordered, reset defaults
// - band compare into condition/event bits 0,1
// - band results routable to three outputs
// - upper limit between setpoint and nominal
// - lower limit between zero and setpoint
// - accepted values rounded to setting resolution
// - lower limit ignored under external control
// - setpoint within limits, reset zero
// - track maximum voltage, overrange code
// - track minimum voltage, underrange code
// - extreme reset loads all four values
// - momentary voltage with signed range code
// - wait delays next command 1..65535 ms
// - wait blocks input and display refresh
// - default dwell 1..65535 ms
module vspl_cmd_core #(
    parameter [16:0] MS_CYC = `VSPL_MS_CYC
) (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire signed [20:0] measVolt,
    input wire measVoltOvr,
    input wire measVoltUnd,
    input wire [19:0] measCurr,
    input wire measCurrOvr,
    input wire extVoltCtrl,
    input wire [3:0] seqLoc,
    output reg [2:0] digSigOut_r,
    output reg [15:0] stepDwellMs_r,
    output reg [19:0] voltSetpoint_r,
    output reg displayHold_r
);

reg [7:0] awAddr_r;
reg awHave_r;
reg [31:0] wData_r;
reg wHave_r;
reg [7:0] ctrl_r;
reg [19:0] uset_r;
reg [19:0] ulh_r;
reg [19:0] ull_r;
reg [19:0] vlo_r;
reg [19:0] vhi_r;
reg [19:0] ilo_r;
reg [19:0] ihi_r;
reg [15:0] locDwell_r [0:15];
reg [3:0] locSel_r;
reg [15:0] default_dwell_time_r;
reg [1:0] crb_r;
reg [3:0] erc_r;
reg signed [20:0] umax_r;
reg signed [20:0] umin_r;
reg [19:0] imax_r;
reg [19:0] imin_r;
reg umaxOvr_r;
reg uminUnd_r;
reg imaxOvr_r;
reg [31:0] rdNxt;
reg wrOk;

wire waitBusy;
wire doWrite = awHave_r & wHave_r & ~s_axi_bvalid & ~waitBusy;
wire awTake = s_axi_awvalid & s_axi_awready;
wire wTake = s_axi_wvalid & s_axi_wready;
wire arTake = s_axi_arvalid & s_axi_arready;
wire wide = (wData_r[31:20] != 12'h000);
wire [20:0] rndSum = {1'b0, wData_r[19:0]} + `VSPL_RES_HALF;
wire [20:0] rnd21 = (rndSum / `VSPL_RES) * `VSPL_RES;
wire [19:0] wVal = rnd21[19:0];
wire rndOvf = rnd21[20] | wide;
wire [15:0] wMs = wData_r[15:0];
wire msWide = (wData_r[31:16] != 16'h0000);
wire [19:0] usetLow = extVoltCtrl ? `VSPL_RST_ZERO : ull_r;
wire minmaxOn = ctrl_r[`VSPL_CTRL_EXTREME_VALUE_TRACKING];
wire vOut = measVoltOvr | measVoltUnd | (measVolt < $signed({1'b0, vlo_r}))
    | (measVolt > $signed({1'b0, vhi_r}));
wire iOut = measCurrOvr | (measCurr < ilo_r) | (measCurr > ihi_r);
wire [2:0] bandSel [0:3];
wire waitStart = doWrite & (awAddr_r == `VSPL_A_WAIT) & ~msWide & (wMs != 16'h0000);
wire wrLim = (awAddr_r == `VSPL_A_USET) | (awAddr_r == `VSPL_A_ULH)
    | (awAddr_r == `VSPL_A_ULL);

assign bandSel[0] = 3'b000;
assign bandSel[1] = {3{vOut}};
assign bandSel[2] = {3{iOut}};
assign bandSel[3] = {3{vOut | iOut}};

vspl_ms_timer #(
    .MS_CYC(MS_CYC)
) i_vspl_ms_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(waitStart),
    .loadMs(wMs),
    .busy_r(waitBusy),
    .done_r()
);

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : sigRoute
        always @(posedge core_clk) begin
            if (!rst_n) begin
                digSigOut_r[g] <= 1'b0;
            end else begin
                digSigOut_r[g] <= bandSel[ctrl_r[`VSPL_CTRL_SIG_LSB + 2*g +: 2]][g];
            end
        end
    end
endgenerate

// value check of the pending write
always @* begin
    wrOk = 1'b1;
    case (awAddr_r)
        `VSPL_A_USET: wrOk = !rndOvf && wVal >= usetLow && wVal <= ulh_r;
        `VSPL_A_ULH: wrOk = !rndOvf && wVal >= uset_r && wVal <= `VSPL_UNOM;
        `VSPL_A_ULL: wrOk = !rndOvf && wVal <= uset_r;
        `VSPL_A_VLO: wrOk = !rndOvf && wVal < vhi_r;
        `VSPL_A_VHI: wrOk = !rndOvf && wVal > vlo_r && wVal <= `VSPL_UNOM;
        `VSPL_A_ILO: wrOk = !rndOvf && wVal < ihi_r;
        `VSPL_A_IHI: wrOk = !rndOvf && wVal > ilo_r && wVal <= `VSPL_INOM;
        `VSPL_A_LOCATION_DWELL_TIME: wrOk = !msWide;
        `VSPL_A_DEFAULT_DWELL_TIME, `VSPL_A_WAIT: wrOk = !msWide && wMs != 16'h0000;
        default: wrOk = 1'b1;
    endcase
end

integer k;

always @(posedge core_clk) begin
    if (!rst_n) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `VSPL_RESP_OKAY;
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        awAddr_r <= 8'h00;
        wData_r <= 32'h00000000;
        ctrl_r <= 8'h00;
        uset_r <= `VSPL_RST_ZERO;
        ulh_r <= `VSPL_UNOM;
        ull_r <= `VSPL_RST_ZERO;
        vlo_r <= `VSPL_RST_ZERO;
        vhi_r <= `VSPL_UNOM;
        ilo_r <= `VSPL_RST_ZERO;
        ihi_r <= `VSPL_INOM;
        for (k = 0; k < 16; k = k + 1) begin
            locDwell_r[k] <= `VSPL_RST_LOCATION_DWELL_TIME;
        end
        locSel_r <= 4'h0;
        default_dwell_time_r <= `VSPL_RST_DEFAULT_DWELL_TIME;
        erc_r <= 4'h0;
        crb_r <= 2'b00;
    end else begin
        s_axi_awready <= ~awHave_r & ~awTake & ~waitBusy;
        s_axi_wready <= ~wHave_r & ~wTake & ~waitBusy;
        if (awTake) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end
        if (wTake) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        crb_r <= {iOut, vOut};
        if (doWrite) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `VSPL_RESP_OKAY;
        end
        // set wins over clear
        erc_r <= (erc_r & ~((doWrite && awAddr_r == `VSPL_A_ERC) ? wData_r[3:0] : 4'h0))
            | {2'b00, iOut, vOut};
        if (doWrite && !wrOk) begin
            erc_r[wrLim ? `VSPL_EV_LIMIT : `VSPL_EV_CMD] <= 1'b1;
        end
        if (doWrite && wrOk) begin
            case (awAddr_r)
                `VSPL_A_CTRL: ctrl_r <= wData_r[7:0];
                `VSPL_A_USET: uset_r <= wVal;
                `VSPL_A_ULH: ulh_r <= wVal;
                `VSPL_A_ULL: ull_r <= wVal;
                `VSPL_A_VLO: vlo_r <= wVal;
                `VSPL_A_VHI: vhi_r <= wVal;
                `VSPL_A_ILO: ilo_r <= wVal;
                `VSPL_A_IHI: ihi_r <= wVal;
                `VSPL_A_LOCATION_DWELL_TIME: locDwell_r[locSel_r] <= wMs;
                `VSPL_A_LOCSEL: locSel_r <= wData_r[3:0];
                `VSPL_A_DEFAULT_DWELL_TIME: default_dwell_time_r <= wMs;
                `VSPL_A_WAIT, `VSPL_A_ERC, `VSPL_A_XRST: begin
                end
                default: s_axi_bresp <= `VSPL_RESP_SLVERR;
            endcase
        end
    end
end

// extreme-value memory
always @(posedge core_clk) begin
    if (!rst_n) begin
        umax_r <= 21'sh000000;
        umin_r <= 21'sh000000;
        imax_r <= `VSPL_RST_ZERO;
        imin_r <= `VSPL_RST_ZERO;
        umaxOvr_r <= 1'b0;
        uminUnd_r <= 1'b0;
        imaxOvr_r <= 1'b0;
    end else if (doWrite && awAddr_r == `VSPL_A_XRST) begin
        umax_r <= measVolt;
        umin_r <= measVolt;
        imax_r <= measCurr;
        imin_r <= measCurr;
        umaxOvr_r <= measVoltOvr;
        uminUnd_r <= measVoltUnd;
        imaxOvr_r <= measCurrOvr;
    end else if (minmaxOn) begin
        if (measVoltOvr) begin
            umaxOvr_r <= 1'b1;
        end else if (!measVoltUnd && measVolt > umax_r) begin
            umax_r <= measVolt;
        end
        if (measVoltUnd) begin
            uminUnd_r <= 1'b1;
        end else if (!measVoltOvr && measVolt < umin_r) begin
            umin_r <= measVolt;
        end
        if (measCurrOvr) begin
            imaxOvr_r <= 1'b1;
        end else begin
            if (measCurr > imax_r) begin
                imax_r <= measCurr;
            end
            if (measCurr < imin_r) begin
                imin_r <= measCurr;
            end
        end
    end
end

always @* begin
    rdNxt = 32'h00000000;
    case (s_axi_araddr)
        `VSPL_A_CTRL: rdNxt = {24'h000000, ctrl_r};
        `VSPL_A_USET: rdNxt = {12'h000, uset_r};
        `VSPL_A_ULH: rdNxt = {12'h000, ulh_r};
        `VSPL_A_ULL: rdNxt = {12'h000, ull_r};
        `VSPL_A_VLO: rdNxt = {12'h000, vlo_r};
        `VSPL_A_VHI: rdNxt = {12'h000, vhi_r};
        `VSPL_A_ILO: rdNxt = {12'h000, ilo_r};
        `VSPL_A_IHI: rdNxt = {12'h000, ihi_r};
        `VSPL_A_LOCATION_DWELL_TIME: rdNxt = {16'h0000, locDwell_r[locSel_r]};
        `VSPL_A_LOCSEL: rdNxt = {28'h0000000, locSel_r};
        `VSPL_A_DEFAULT_DWELL_TIME: rdNxt = {16'h0000, default_dwell_time_r};
        `VSPL_A_CRB: rdNxt = {30'h00000000, crb_r};
        `VSPL_A_ERC: rdNxt = {28'h0000000, erc_r};
        `VSPL_A_UMAX: rdNxt = umaxOvr_r ? `VSPL_OVR_CODE : {{11{umax_r[20]}}, umax_r};
        `VSPL_A_UMIN: rdNxt = uminUnd_r ? `VSPL_UND_CODE : {{11{umin_r[20]}}, umin_r};
        `VSPL_A_IMAX: rdNxt = imaxOvr_r ? `VSPL_OVR_CODE : {12'h000, imax_r};
        `VSPL_A_IMIN: rdNxt = {12'h000, imin_r};
        `VSPL_A_UOUT: begin
            if (measVoltOvr) begin
                rdNxt = `VSPL_OVR_CODE;
            end else if (measVoltUnd) begin
                rdNxt = `VSPL_UND_CODE;
            end else begin
                rdNxt = {{11{measVolt[20]}}, measVolt};
            end
        end
        default: rdNxt = 32'h00000000;
    endcase
end

always @(posedge core_clk) begin
    if (!rst_n) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `VSPL_RESP_OKAY;
        stepDwellMs_r <= `VSPL_RST_DEFAULT_DWELL_TIME;
        voltSetpoint_r <= `VSPL_RST_ZERO;
        displayHold_r <= 1'b0;
    end else begin
        s_axi_arready <= ~arTake & ~s_axi_rvalid & ~waitBusy & ~waitStart;
        if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdNxt;
            s_axi_rresp <= (s_axi_araddr > `VSPL_A_UOUT || s_axi_araddr[1:0] != 2'b00
                || s_axi_araddr == `VSPL_A_WAIT) ? `VSPL_RESP_SLVERR : `VSPL_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
        stepDwellMs_r <= (locDwell_r[seqLoc] == `VSPL_RST_LOCATION_DWELL_TIME) ? default_dwell_time_r
            : locDwell_r[seqLoc];
        voltSetpoint_r <= uset_r;
        displayHold_r <= waitBusy | waitStart;
    end
end

endmodule // vspl_cmd_core

// file: verif/vspl_cmd_core_properties.sv
`timescale 1ns/1ns
module vspl_cmd_core_properties #(
    parameter [16:0] MS_CYC = 17'h186a0
) (
    input wire core_clk,
    input wire rst_n,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_arready,
    input wire s_axi_bvalid,
    input wire s_axi_rvalid,
    input wire [15:0] stepDwellMs_r,
    input wire [19:0] voltSetpoint_r,
    input wire displayHold_r
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_wait_blocks: assert property (displayHold_r |-> !(s_axi_awready | s_axi_arready))
        else $error("bus accepted during wait");
    a_wait_min: assert property ($rose(displayHold_r) |-> displayHold_r[*8])
        else $error("wait ended too early");
    a_wait_cause: assert property ($rose(displayHold_r) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("wait started without write");
    a_set_resol: assert property (voltSetpoint_r % 20'h0000a == 20'h00000)
        else $error("setpoint not rounded");
    a_set_nominal: assert property (voltSetpoint_r <= 20'h927c0)
        else $error("setpoint above nominal");
    a_set_cause: assert property (!$stable(voltSetpoint_r) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("setpoint changed without write");
    a_dwell_nonzero: assert property (stepDwellMs_r != 16'h0000)
        else $error("zero dwell used");
    a_write_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response open");
    a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data open");
    cover property ($rose(displayHold_r));
    cover property (!$stable(voltSetpoint_r));
    cover property (s_axi_rvalid && s_axi_bvalid == 1'b0);
endmodule // vspl_cmd_core_properties

bind vspl_cmd_core vspl_cmd_core_properties #(.MS_CYC(MS_CYC)) i_vspl_cmd_core_properties (
    .core_clk, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_arready, .s_axi_bvalid,
    .s_axi_rvalid, .stepDwellMs_r, .voltSetpoint_r, .displayHold_r
);

// file: verif/vspl_host_model.sv
`timescale 1ns/1ns
module vspl_host_model (
    input wire core_clk,
    output reg [7:0] s_axi_awaddr,
    output reg s_axi_awvalid,
    input wire s_axi_awready,
    output reg [31:0] s_axi_wdata,
    output reg [3:0] s_axi_wstrb,
    output reg s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output reg s_axi_bready,
    output reg [7:0] s_axi_araddr,
    output reg s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output reg s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end
    // payload inverted once taken, so stale values never look valid
    task automatic wr(input [7:0] a, input [31:0] dt, output [1:0] rs, output bit to);
        bit dn;
        begin
            @(posedge core_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= dt;
            s_axi_wstrb <= 4'hf;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            dn = 1'b0;
            for (int n = 0; n < 4000 && !dn; n++) begin
                @(posedge core_clk);
                if (s_axi_awvalid && s_axi_awready) begin
                    s_axi_awvalid <= 1'b0;
                    s_axi_awaddr <= ~a;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    s_axi_wvalid <= 1'b0;
                    s_axi_wdata <= ~dt;
                end
                if (s_axi_bvalid) begin
                    rs = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    dn = 1'b1;
                end
            end
            to = !dn;
        end
    endtask
    task automatic rd(input [7:0] a, output [31:0] dt, output [1:0] rs, output bit to);
        bit dn;
        begin
            @(posedge core_clk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            dn = 1'b0;
            for (int n = 0; n < 4000 && !dn; n++) begin
                @(posedge core_clk);
                if (s_axi_arvalid && s_axi_arready) begin
                    s_axi_arvalid <= 1'b0;
                    s_axi_araddr <= ~a;
                end
                if (s_axi_rvalid) begin
                    dt = s_axi_rdata;
                    rs = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                    dn = 1'b1;
                end
            end
            to = !dn;
        end
    endtask
endmodule // vspl_host_model

// file: verif/vspl_cmd_core_test.sv
`timescale 1ns/1ns
`include "vspl_defs.vh"
`define CHK(nm, e, s) \
    begin \
        numChecks = numChecks + 1; \
        if ((s) !== (e)) begin \
            miscompares = miscompares + 1; \
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s); \
        end \
    end
module vspl_cmd_core_test;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, displayHold_r;
    wire [2:0] digSigOut_r;
    wire [15:0] stepDwellMs_r;
    wire [19:0] voltSetpoint_r;
    reg signed [20:0] measVolt = 21'h003e8;
    reg [19:0] measCurr = 20'h003e8;
    reg measVoltOvr = 1'b0, measVoltUnd = 1'b0, measCurrOvr = 1'b0, extVoltCtrl = 1'b0;
    reg [3:0] seqLoc = 4'h0;
    integer seed = 2010, numChecks = 0, miscompares = 0, i, k;
    reg [31:0] d, rn;
    reg [1:0] r;
    reg [19:0] w, rw;
    reg [19:0] lim [3];
    reg ok;
    time t0;
    integer ck [6] = '{0, 1, 0, 2, 0, 0};
    reg [19:0] cw [6] = '{20'h1d4c4, 20'h1d4bc, 20'h1d4c6, 20'h1d4c4, 20'h1d0d8, 20'h1d2cc};
    reg ce [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    vspl_host_model i_vspl_host_model (
        .core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    vspl_cmd_core #(.MS_CYC(17'h0000a)) i_vspl_cmd_core (
        .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .measVolt, .measVoltOvr, .measVoltUnd,
        .measCurr, .measCurrOvr, .extVoltCtrl, .seqLoc, .digSigOut_r, .stepDwellMs_r,
        .voltSetpoint_r, .displayHold_r
    );
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task results;
        begin
            $display("checks %0d miscompares %0d", numChecks, miscompares);
            if (miscompares == 0 && numChecks > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] dt);
        bit to;
        begin
            i_vspl_host_model.wr(a, dt, r, to);
            if (to) begin
                miscompares = miscompares + 1;
                results;
            end
        end
    endtask
    task automatic rd(input [7:0] a);
        bit to;
        begin
            i_vspl_host_model.rd(a, d, r, to);
            if (to) begin
                miscompares = miscompares + 1;
                results;
            end
        end
    endtask
    task automatic rdc(input [7:0] a, input [31:0] e);
        begin
            rd(a);
            `CHK($sformatf("reg %h", a), e, d)
        end
    endtask
    task automatic event_register_c(input integer b, input e);
        begin
            rd(8'h34);
            `CHK("event bit", e, d[b])
            wr(8'h34, 32'h1 << b);
        end
    endtask
    task automatic dw(input [15:0] e);
        begin
            repeat (2) @(posedge core_clk);
            `CHK("dwell", e, stepDwellMs_r)
        end
    endtask
    function automatic [31:0] dflt(input integer n);
        case (n)
            2, 5: dflt = {12'h000, `VSPL_UNOM};
            7: dflt = {12'h000, `VSPL_INOM};
            10: dflt = {16'h0000, `VSPL_RST_DEFAULT_DWELL_TIME};
            default: dflt = 32'h0;
        endcase
    endfunction
    function automatic bit accept(input integer n, input [19:0] x);
        case (n)
            0: accept = (extVoltCtrl || x >= lim[2]) && x <= lim[1];
            1: accept = x >= lim[0] && x <= `VSPL_UNOM;
            default: accept = x <= lim[0];
        endcase
    endfunction
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            rdc(8'(4 * i), dflt(i));
            `CHK("rresp", (i == 11) ? 2'b10 : 2'b00, r)
        end
        rdc(8'h34, 32'h0);
        rd(8'h50);
        `CHK("rresp", 2'b10, r)
        wr(8'h50, 32'h0);
        `CHK("bresp", 2'b10, r)
        lim = '{20'h00000, `VSPL_UNOM, 20'h00000};
        for (i = 0; i < 46; i = i + 1) begin
            rn = $random(seed);
            k = (i < 6) ? ck[i] : rn[31:16] % 3;
            w = (i < 6) ? cw[i] : rn[19:0] % 20'h92800;
            extVoltCtrl <= (i < 6) ? ce[i] : rn[20];
            @(posedge core_clk);
            rw = 20'((w + 20'h5) / 20'ha * 20'ha);
            ok = accept(k, rw);
            wr(8'(4 * k + 4), {12'h000, w});
            if (ok) lim[k] = rw;
            rdc(8'(4 * k + 4), {12'h000, lim[k]});
            event_register_c(2, !ok);
        end
        `CHK("setpoint", lim[0], voltSetpoint_r)
        wr(8'h10, 32'h186a0);
        wr(8'h14, 32'h30d40);
        wr(8'h14, 32'h186a0);
        event_register_c(3, 1'b1);
        rdc(8'h14, 32'h30d40);
        wr(8'h00, 32'he5);
        for (i = 0; i < 4; i = i + 1) begin
            measVolt <= i[0] ? 21'h0c350 : 21'h249f0;
            measCurr <= i[1] ? 20'h249f0 : 20'h003e8;
            repeat (3) @(posedge core_clk);
            rdc(8'h30, {30'h0, i[1:0]});
            `CHK("route", {i[0] | i[1], i[1], i[0]}, digSigOut_r)
        end
        rd(8'h34);
        `CHK("band events", 2'b11, d[1:0])
        measVolt <= 21'h249f0;
        repeat (3) @(posedge core_clk);
        wr(8'h4c, 32'h0);
        rdc(8'h38, 32'h249f0);
        rdc(8'h44, 32'h249f0);
        measVolt <= 21'h493e0;
        repeat (3) @(posedge core_clk);
        measVolt <= 21'h15f90;
        repeat (3) @(posedge core_clk);
        rdc(8'h38, 32'h493e0);
        rdc(8'h3c, 32'h15f90);
        rdc(8'h48, 32'h15f90);
        measVoltOvr <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(8'h48, `VSPL_OVR_CODE);
        measVoltOvr <= 1'b0;
        measVoltUnd <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(8'h48, `VSPL_UND_CODE);
        measVoltUnd <= 1'b0;
        rdc(8'h38, `VSPL_OVR_CODE);
        rdc(8'h3c, `VSPL_UND_CODE);
        wr(8'h24, 32'h3);
        seqLoc <= 4'h3;
        dw(16'h0001);
        wr(8'h28, 32'h7);
        dw(16'h0007);
        wr(8'h20, 32'hffff);
        dw(16'hffff);
        // host sets a second location to full length and checks the step dwell there
        wr(8'h24, 32'h4);
        wr(8'h20, 32'hffff);
        seqLoc <= 4'h4;
        dw(16'hffff);
        wr(8'h20, 32'h10000);
        event_register_c(3, 1'b1);
        seqLoc <= 4'h2;
        dw(16'h0007);
        wr(8'h28, 32'h0);
        event_register_c(3, 1'b1);
        rdc(8'h28, 32'h7);
        wr(8'h2c, 32'h0);
        event_register_c(3, 1'b1);
        extVoltCtrl <= 1'b1;
        t0 = $time;
        wr(8'h2c, 32'h3);
        wr(8'h04, {12'h000, lim[1]});
        `CHK("wait", 1'b1, ($time - t0) >= 300 && ($time - t0) < 500)
        // setpoint output follows the stored value one edge later
        @(posedge core_clk);
        `CHK("order", lim[1], voltSetpoint_r)
        results;
    end
endmodule // vspl_cmd_core_test
